// file: flash_fe_pkg.sv
// Shared constants, types and decoders for the flash front end
package flash_fe_pkg;

  // Array and buffer organisation
  localparam int PAGE_COUNT = 8192;
  localparam int PAGE_ADDR_W = 13;
  localparam int BYTE_ADDR_W = 11;
  localparam logic [10:0] PAGE_BYTES_BIN = 11'h400;
  localparam logic [10:0] PAGE_BYTES_STD = 11'h420;
  localparam int BUF_DEPTH_STD = 1056;
  localparam int BUF_COUNT = 2;
  localparam int SEC_USER_BYTES = 64;
  localparam int SEC_ID_BYTES = 64;
  localparam logic [1:0] ADDR_UNITS = 2'h3;

  // Opcodes; bit 0 selects the buffer where one applies
  localparam logic [6:0] OPC_BUF_WRITE = 7'h08;
  localparam logic [6:0] OPC_BUF_READ = 7'h09;
  localparam logic [6:0] OPC_PROGRAM = 7'h10;
  localparam logic [6:0] OPC_ERASE = 7'h11;
  localparam logic [6:0] OPC_STATUS = 7'h18;
  localparam logic [6:0] OPC_SEC_READ = 7'h19;
  localparam logic [6:0] OPC_SEC_PROG = 7'h1A;

  // Status byte layout
  localparam int ST_READY_BIT = 7;
  localparam int ST_BUSY_BUF_BIT = 1;
  localparam int ST_BINARY_BIT = 0;

  // Self-timed durations
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_PROG_NS = 3000000;
  localparam int T_ERASE_NS = 4000000;
  localparam int T_SEC_PROG_NS = 200000;
  localparam int SEC_PROG_CYC = (T_SEC_PROG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [1:0] {
    F_IDLE = 2'b00,
    F_OPCODE = 2'b01,
    F_ADDR = 2'b11,
    F_DATA = 2'b10
  } frame_t;

  typedef enum logic [1:0] {
    B_IDLE = 2'b00,
    B_RUN = 2'b01,
    B_DRAIN = 2'b11
  } busy_t;

  typedef enum logic [2:0] {
    C_NONE, C_BUF_WR, C_BUF_RD, C_PROG, C_ERASE, C_STATUS, C_SEC_RD, C_SEC_PROG
  } cmd_t;

  function automatic cmd_t decode_cmd(input logic [7:0] op);
    case (op[7:1])
      OPC_BUF_WRITE: decode_cmd = C_BUF_WR;
      OPC_BUF_READ: decode_cmd = C_BUF_RD;
      OPC_PROGRAM: decode_cmd = C_PROG;
      OPC_ERASE: decode_cmd = C_ERASE;
      OPC_STATUS: decode_cmd = C_STATUS;
      OPC_SEC_READ: decode_cmd = C_SEC_RD;
      OPC_SEC_PROG: decode_cmd = C_SEC_PROG;
      default: decode_cmd = C_NONE;
    endcase
  endfunction

  function automatic logic is_read(input cmd_t c);
    is_read = (c == C_BUF_RD) || (c == C_STATUS) || (c == C_SEC_RD);
  endfunction

  function automatic logic [10:0] next_ptr(input logic [10:0] p, input logic [10:0] size);
    next_ptr = (p == size - 11'h001) ? 11'h000 : p + 11'h001;
  endfunction

endpackage

// file: flash_fe_sva.sv
// Pin-level checks on the flash front end
`timescale 1ns/10ps
module flash_fe_sva
  import flash_fe_pkg::*;
(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Watched pins
  input wire logic I_DEVICE_SELECT_N,
  input wire logic I_ARRAY_WREADY,
  input wire logic O_SERIAL_DATA_OE,
  input wire logic O_BYTE_LANE_OE,
  input wire logic O_OP_PENDING_N,
  input wire logic O_OP_PENDING_OE,
  input wire logic O_ARRAY_PROG,
  input wire logic O_ARRAY_ERASE,
  input wire logic [PAGE_ADDR_W-1:0] O_ARRAY_PAGE,
  input wire logic O_ARRAY_WVALID,
  input wire logic [7:0] O_ARRAY_WDATA,
  input wire logic O_STANDBY
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SYS_RST);
  // Select pin has been high long enough to pass the synchroniser
  logic [3:0] desel;
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || !I_DEVICE_SELECT_N) begin
      desel <= 4'h0;
    end else if (desel != 4'hF) begin
      desel <= desel + 4'h1;
    end
  end
  sequence start_s;
    O_ARRAY_PROG || O_ARRAY_ERASE;
  endsequence
  sequence busy_s;
    O_OP_PENDING_OE && $past(O_OP_PENDING_OE);
  endsequence
  out_release_a: assert property (desel >= 4'h8 |-> !O_SERIAL_DATA_OE && !O_BYTE_LANE_OE)
    else $error("output enabled while deselected");
  busy_active_a: assert property (busy_s |-> !O_STANDBY)
    else $error("standby during self-timed operation");
  select_wake_a: assert property (!I_DEVICE_SELECT_N [*8] |-> !O_STANDBY)
    else $error("standby while selected");
  pend_hold_a: assert property (start_s |-> ##[0:1] O_OP_PENDING_OE [*8])
    else $error("pending not held after start");
  pend_level_a: assert property (O_OP_PENDING_OE |-> !O_OP_PENDING_N)
    else $error("pending pin not pulled low");
  start_desel_a: assert property (start_s |-> I_DEVICE_SELECT_N && $past(I_DEVICE_SELECT_N, 2))
    else $error("start without frame end");
  no_restart_a: assert property (busy_s |-> !O_ARRAY_PROG && !O_ARRAY_ERASE)
    else $error("start accepted while busy");
  page_stand_a: assert property (busy_s |-> $stable(O_ARRAY_PAGE))
    else $error("page changed while busy");
  wdata_hold_a: assert property (O_ARRAY_WVALID && !I_ARRAY_WREADY |=>
    O_ARRAY_WVALID && $stable(O_ARRAY_WDATA))
    else $error("stream word dropped under stall");
  done_standby_a: assert property ($fell(O_OP_PENDING_OE) && desel >= 4'h8 |->
    ##[0:1] O_STANDBY)
    else $error("no standby after operation end");
  oe_exclusive_a: assert property (!(O_SERIAL_DATA_OE && O_BYTE_LANE_OE))
    else $error("both outputs enabled");
endmodule
bind flash_front_end flash_fe_sva u_sva (
  .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_DEVICE_SELECT_N(I_DEVICE_SELECT_N),
  .I_ARRAY_WREADY(I_ARRAY_WREADY), .O_SERIAL_DATA_OE(O_SERIAL_DATA_OE),
  .O_BYTE_LANE_OE(O_BYTE_LANE_OE), .O_OP_PENDING_N(O_OP_PENDING_N),
  .O_OP_PENDING_OE(O_OP_PENDING_OE), .O_ARRAY_PROG(O_ARRAY_PROG),
  .O_ARRAY_ERASE(O_ARRAY_ERASE), .O_ARRAY_PAGE(O_ARRAY_PAGE),
  .O_ARRAY_WVALID(O_ARRAY_WVALID), .O_ARRAY_WDATA(O_ARRAY_WDATA), .O_STANDBY(O_STANDBY)
);

// file: flash_front_end.sv
// Host-facing front end: framing, serial/byte link, buffers, self-timed ops
`timescale 1ns/10ps
module flash_front_end
  import flash_fe_pkg::*;
#(
  parameter int BUF_DEPTH = BUF_DEPTH_STD,
  parameter int PROG_CYC = T_PROG_NS / CLK_PERIOD_NS,
  parameter int ERASE_CYC = T_ERASE_NS / CLK_PERIOD_NS,
  // Arbitrary identifier pattern, not tied to any part
  parameter logic [SEC_ID_BYTES*8-1:0] UNIQUE_ID = {SEC_ID_BYTES{8'hA5}}
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SYS_RST,
  // Link pins
  input wire logic I_LINK_CLK,
  input wire logic I_DEVICE_SELECT_N,
  input wire logic I_INTERFACE_SELECT,
  input wire logic I_SERIAL_DATA_IN,
  output logic O_SERIAL_DATA_OUT,
  output logic O_SERIAL_DATA_OE,
  input wire logic [7:0] I_BYTE_LANE,
  output logic [7:0] O_BYTE_LANE,
  output logic O_BYTE_LANE_OE,
  // Open-drain busy pin
  output logic O_OP_PENDING_N,
  output logic O_OP_PENDING_OE,
  // Configuration strap
  input wire logic I_BINARY_PAGE,
  // Array side
  output logic O_ARRAY_PROG,
  output logic O_ARRAY_ERASE,
  output logic [PAGE_ADDR_W-1:0] O_ARRAY_PAGE,
  output logic O_ARRAY_WVALID,
  input wire logic I_ARRAY_WREADY,
  output logic [7:0] O_ARRAY_WDATA,
  // Power state
  output logic O_STANDBY
);

  localparam int SYNC_W = 13;

  logic [SYNC_W-1:0] pins_lvl;
  logic link_clk;
  logic sel_n;
  logic serial_mode;
  logic sdi;
  logic [7:0] lane_in;
  logic binary_page;
  logic link_clk_q;
  logic sel_n_q;
  logic clk_rise;
  logic clk_fall;
  logic frame_end;

  frame_t frame;
  cmd_t cmd;
  logic [7:0] opcode;
  logic [2:0] bit_cnt;
  logic [6:0] rx_shift;
  logic unit_valid;
  logic [7:0] unit_data;
  logic [1:0] addr_cnt;
  logic [15:0] addr_hi;
  logic [23:0] full_addr;
  logic [PAGE_ADDR_W-1:0] page;
  logic [10:0] ptr;
  logic [10:0] page_bytes;

  logic [7:0] mem [BUF_COUNT][BUF_DEPTH];
  logic [7:0] sec_user [SEC_USER_BYTES];
  logic [7:0] rd_byte;
  logic [6:0] tx_shift;
  logic [2:0] tx_cnt;

  busy_t busy;
  cmd_t busy_kind;
  logic busy_buf;
  logic [31:0] timer;
  logic [10:0] stream_idx;
  logic stream_done;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic start_op;

  pin_sync #(
    .W(SYNC_W),
    .RST_VAL(13'h0C00)
  ) u_sync (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_pin({I_LINK_CLK, I_DEVICE_SELECT_N, I_INTERFACE_SELECT, I_SERIAL_DATA_IN,
            I_BYTE_LANE, I_BINARY_PAGE}),
    .o_level(pins_lvl)
  );

  assign link_clk = pins_lvl[12];
  assign sel_n = pins_lvl[11];
  assign serial_mode = pins_lvl[10];
  assign sdi = pins_lvl[9];
  assign lane_in = pins_lvl[8:1];
  assign binary_page = pins_lvl[0];

  assign page_bytes = binary_page ? PAGE_BYTES_BIN : PAGE_BYTES_STD;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      link_clk_q <= 1'b0;
      sel_n_q <= 1'b1;
    end else begin
      link_clk_q <= link_clk;
      sel_n_q <= sel_n;
    end
  end

  // only edges matter, so the idle level of mode 0 or 3 is irrelevant
  assign clk_rise = link_clk && !link_clk_q;
  assign clk_fall = !link_clk && link_clk_q;
  assign frame_end = sel_n && !sel_n_q;

  // sampling is gated by select; on rising edges only
  // serial units come from serial data in; byte units from the lane
  assign unit_valid = clk_rise && !sel_n && frame != F_IDLE &&
                      (!serial_mode || bit_cnt == 3'h7);
  assign unit_data = serial_mode ? {rx_shift, sdi} : lane_in;
  assign full_addr = {addr_hi, unit_data};

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || sel_n) begin
      bit_cnt <= 3'h0;
      rx_shift <= 7'h00;
    end else if (clk_rise && serial_mode) begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_shift <= {rx_shift[5:0], sdi};
    end
  end

  // Frame sequencing
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      frame <= F_IDLE;
      cmd <= C_NONE;
      opcode <= 8'h00;
      addr_cnt <= 2'h0;
      addr_hi <= 16'h0000;
      page <= '0;
    // a frame cut short simply returns to idle
    end else if (sel_n) begin
      frame <= F_IDLE;
    end else begin
      case (frame)
        F_IDLE: begin
          // falling select opens a fresh frame
          if (sel_n_q) begin
            frame <= F_OPCODE;
            cmd <= C_NONE;
            addr_cnt <= 2'h0;
          end
        end
        F_OPCODE: begin
          if (unit_valid) begin
            opcode <= unit_data;
            cmd <= decode_cmd(unit_data);
            if (decode_cmd(unit_data) == C_STATUS || decode_cmd(unit_data) == C_NONE) begin
              frame <= F_DATA;
            end else begin
              frame <= F_ADDR;
            end
          end
        end
        F_ADDR: begin
          if (unit_valid) begin
            addr_hi <= full_addr[15:0];
            addr_cnt <= addr_cnt + 2'h1;
            if (addr_cnt == ADDR_UNITS - 2'h1) begin
              frame <= F_DATA;
              page <= full_addr[23:BYTE_ADDR_W];
            end
          end
        end
        F_DATA: begin
          frame <= F_DATA;
        end
        default: begin
          frame <= F_IDLE;
        end
      endcase
    end
  end

  // Byte pointer: set by the address, advanced by each data unit
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      ptr <= 11'h000;
    end else if (frame == F_OPCODE) begin
      ptr <= 11'h000;
    end else if (frame == F_ADDR && unit_valid && addr_cnt == ADDR_UNITS - 2'h1) begin
      ptr <= (full_addr[10:0] >= page_bytes) ? 11'h000 : full_addr[10:0];
    end else if (frame == F_DATA && !sel_n) begin
      if (unit_valid && !is_read(cmd)) begin
        ptr <= next_ptr(ptr, page_bytes);
      end else if (clk_fall && is_read(cmd) && (!serial_mode || tx_cnt == 3'h0)) begin
        ptr <= next_ptr(ptr, page_bytes);
      end
    end
  end

  // Buffer writes; the buffer being programmed is locked, the other is free
  always_ff @(posedge I_CLK) begin
    if (frame == F_DATA && unit_valid && cmd == C_BUF_WR &&
        !(busy != B_IDLE && busy_kind == C_PROG && busy_buf == opcode[0])) begin
      mem[opcode[0]][ptr] <= unit_data;
    end
  end

  // only the user half of the security area is writable
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      for (int i = 0; i < SEC_USER_BYTES; i++) begin
        sec_user[i] <= 8'hFF;
      end
    end else if (frame == F_DATA && unit_valid && cmd == C_SEC_PROG && busy == B_IDLE &&
                 ptr < 11'(SEC_USER_BYTES)) begin
      sec_user[ptr[5:0]] <= unit_data;
    end
  end

  // Read source selection
  always_comb begin
    rd_byte = 8'h00;
    case (cmd)
      C_STATUS: begin
        rd_byte[ST_READY_BIT] = (busy == B_IDLE);
        rd_byte[ST_BUSY_BUF_BIT] = busy_buf;
        rd_byte[ST_BINARY_BIT] = binary_page;
      end
      C_BUF_RD: rd_byte = mem[opcode[0]][ptr];
      C_SEC_RD: begin
        if (ptr[6] == 1'b0) begin
          rd_byte = sec_user[ptr[5:0]];
        end else begin
          rd_byte = UNIQUE_ID[{ptr[5:0], 3'h0} +: 8];
        end
      end
      default: rd_byte = 8'h00;
    endcase
  end

  // read data launched on falling edges
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || sel_n) begin
      tx_shift <= 7'h00;
      tx_cnt <= 3'h0;
      O_SERIAL_DATA_OUT <= 1'b0;
      O_BYTE_LANE <= 8'h00;
    end else if (clk_fall && frame == F_DATA && is_read(cmd)) begin
      if (serial_mode) begin
        if (tx_cnt == 3'h0) begin
          O_SERIAL_DATA_OUT <= rd_byte[7];
          tx_shift <= rd_byte[6:0];
        end else begin
          O_SERIAL_DATA_OUT <= tx_shift[6];
          tx_shift <= {tx_shift[5:0], 1'b0};
        end
        tx_cnt <= tx_cnt + 3'h1;
      end else begin
        O_BYTE_LANE <= rd_byte;
      end
    end
  end

  // drivers enabled only inside a selected read frame
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || sel_n) begin
      O_SERIAL_DATA_OE <= 1'b0;
      O_BYTE_LANE_OE <= 1'b0;
    end else if (clk_fall && frame == F_DATA && is_read(cmd)) begin
      O_SERIAL_DATA_OE <= serial_mode;
      O_BYTE_LANE_OE <= !serial_mode;
    end
  end

  // only complete commands that reached the data phase start anything
  assign start_op = frame_end && frame == F_DATA && busy == B_IDLE &&
                    (cmd == C_PROG || cmd == C_ERASE || cmd == C_SEC_PROG);

  // self-timed sequencer, no link clock needed once running
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      busy <= B_IDLE;
      busy_kind <= C_NONE;
      busy_buf <= 1'b0;
      timer <= 32'h0;
      O_ARRAY_PROG <= 1'b0;
      O_ARRAY_ERASE <= 1'b0;
      O_ARRAY_PAGE <= '0;
    end else begin
      O_ARRAY_PROG <= 1'b0;
      O_ARRAY_ERASE <= 1'b0;
      case (busy)
        B_IDLE: begin
          if (start_op) begin
            busy <= B_RUN;
            busy_kind <= cmd;
            busy_buf <= opcode[0];
            O_ARRAY_PAGE <= page;
            O_ARRAY_PROG <= (cmd == C_PROG);
            O_ARRAY_ERASE <= (cmd == C_ERASE);
            case (cmd)
              C_PROG: timer <= 32'(PROG_CYC);
              C_ERASE: timer <= 32'(ERASE_CYC);
              default: timer <= 32'(SEC_PROG_CYC);
            endcase
          end
        end
        B_RUN: begin
          if (timer != 32'h0) begin
            timer <= timer - 32'h1;
          end else begin
            busy <= B_DRAIN;
          end
        end
        B_DRAIN: begin
          // Page data must have left the buffer before the array is released
          if (busy_kind != C_PROG || (stream_done && !fifo_out_valid)) begin
            busy <= B_IDLE;
          end
        end
        default: busy <= B_IDLE;
      endcase
    end
  end

  // Page data stream toward the array; stalls while the buffer is full
  assign fifo_in_valid = busy != B_IDLE && busy_kind == C_PROG && !stream_done;

  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST || busy == B_IDLE) begin
      stream_idx <= 11'h000;
      stream_done <= 1'b0;
    end else if (fifo_in_valid && fifo_in_ready) begin
      stream_idx <= stream_idx + 11'h001;
      stream_done <= (stream_idx == page_bytes - 11'h001);
    end
  end

  skid_buf2 #(
    .W(8)
  ) u_stream (
    .i_clk(I_CLK),
    .i_rst(I_SYS_RST),
    .i_valid(fifo_in_valid),
    .o_ready(fifo_in_ready),
    .i_data(mem[busy_buf][stream_idx]),
    .o_valid(fifo_out_valid),
    .i_ready(I_ARRAY_WREADY),
    .o_data(O_ARRAY_WDATA)
  );

  assign O_ARRAY_WVALID = fifo_out_valid;

  // busy pin pulled low while any self-timed work runs
  assign O_OP_PENDING_N = 1'b0;
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_OP_PENDING_OE <= 1'b0;
    end else begin
      O_OP_PENDING_OE <= (busy != B_IDLE) || start_op;
    end
  end

  // deselect means standby; not before the running operation ends
  always_ff @(posedge I_CLK) begin
    if (I_SYS_RST) begin
      O_STANDBY <= 1'b1;
    end else begin
      O_STANDBY <= sel_n && busy == B_IDLE && !start_op;
    end
  end

endmodule

// file: flash_front_end_test.sv
// Self-checking bench for the flash front end
`timescale 1ns/10ps
module flash_front_end_test;
  import flash_fe_pkg::*;
  logic I_CLK, I_SYS_RST, I_INTERFACE_SELECT, I_BINARY_PAGE, I_ARRAY_WREADY;
  logic lclk, sel_n, sdi, sdo, sdo_oe, lane_oe, pend_n, pend_oe, prog, erase, wvalid, standby;
  logic [7:0] host_lane, dut_lane, lane, wdata;
  logic [PAGE_ADDR_W-1:0] page;
  logic [7:0] stream[$];
  int mismatches = 0, n_compared = 0, cycles = 0, n_prog = 0, n_erase = 0;
  wire busy_pin = pend_oe ? pend_n : 1'b1;
  assign lane = lane_oe ? dut_lane : host_lane;
  flash_front_end #(.PROG_CYC(50), .ERASE_CYC(60)) u_dut (
    .I_CLK(I_CLK), .I_SYS_RST(I_SYS_RST), .I_LINK_CLK(lclk), .I_DEVICE_SELECT_N(sel_n),
    .I_INTERFACE_SELECT(I_INTERFACE_SELECT), .I_SERIAL_DATA_IN(sdi),
    .O_SERIAL_DATA_OUT(sdo), .O_SERIAL_DATA_OE(sdo_oe), .I_BYTE_LANE(lane),
    .O_BYTE_LANE(dut_lane), .O_BYTE_LANE_OE(lane_oe), .O_OP_PENDING_N(pend_n),
    .O_OP_PENDING_OE(pend_oe), .I_BINARY_PAGE(I_BINARY_PAGE), .O_ARRAY_PROG(prog),
    .O_ARRAY_ERASE(erase), .O_ARRAY_PAGE(page), .O_ARRAY_WVALID(wvalid),
    .I_ARRAY_WREADY(I_ARRAY_WREADY), .O_ARRAY_WDATA(wdata), .O_STANDBY(standby)
  );
  link_host u_host (.o_lclk(lclk), .o_sel_n(sel_n), .o_sdi(sdi), .o_lane(host_lane),
    .i_sdo(sdo_oe ? sdo : 1'bz), .i_lane(lane));
  initial begin
    I_CLK = 1'b0;
    forever #25 I_CLK = ~I_CLK;
  end
  // Array side stalls two cycles of every four
  always @(posedge I_CLK) begin
    cycles <= cycles + 1;
    I_ARRAY_WREADY <= cycles[1];
    if (wvalid && I_ARRAY_WREADY) stream.push_back(wdata);
    if (prog) n_prog <= n_prog + 1;
    if (erase) n_erase <= n_erase + 1;
    if (cycles == 40000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (pend_oe !== 1'b0 && k < 8000) begin
      @(posedge I_CLK);
      k++;
    end
    chk(k < 8000, 1'b1);
    repeat (3) @(posedge I_CLK);
  endtask
  task automatic t_serial();
    u_host.run('{8'h10, 8'h00, 8'h04, 8'h1F, 8'h3C, 8'hC3}, 0, 0, 0);
    u_host.run('{8'h12, 8'h00, 8'h04, 8'h1F}, 2, 0, 0);
    chk(u_host.rx[0], 8'h3C);
    chk(u_host.rx[1], 8'hC3);
    chk(sdo_oe, 1'b0);
    u_host.run('{8'h12, 8'h00, 8'h04, 8'h1F}, 1, 0, 1);
    chk(u_host.rx[0], 8'h3C);
  endtask
  task automatic t_partial();
    u_host.noise();
    u_host.run('{8'h20, 8'h00}, 0, 0, 0);
    repeat (20) @(posedge I_CLK);
    chk(n_prog, 0);
    chk(busy_pin, 1'b1);
    chk(standby, 1'b1);
  endtask
  task automatic t_byte();
    @(posedge I_CLK);
    I_INTERFACE_SELECT <= 1'b0;
    I_BINARY_PAGE <= 1'b1;
    u_host.run('{8'h11, 8'h00, 8'h03, 8'hFF, 8'h5A, 8'hA5}, 0, 1, 0);
    u_host.run('{8'h13, 8'h00, 8'h03, 8'hFF}, 2, 1, 0);
    chk({u_host.rx[0], u_host.rx[1]}, 16'h5AA5);
    chk(lane_oe, 1'b0);
    u_host.run('{8'h13, 8'h00, 8'h00, 8'h00}, 1, 1, 0);
    chk(u_host.rx[0], 8'hA5);
    @(posedge I_CLK);
    I_INTERFACE_SELECT <= 1'b1;
    I_BINARY_PAGE <= 1'b0;
  endtask
  task automatic t_program();
    stream.delete();
    u_host.run('{8'h20, 8'h00, 8'h28, 8'h00}, 0, 0, 0);
    chk(n_prog, 1);
    chk(page, 13'h0005);
    chk(busy_pin, 1'b0);
    chk(standby, 1'b0);
    u_host.run('{8'h10, 8'h00, 8'h00, 8'h00, 8'h99}, 0, 0, 0);
    u_host.run('{8'h11, 8'h00, 8'h00, 8'h02, 8'h77}, 0, 0, 0);
    u_host.run('{8'h13, 8'h00, 8'h00, 8'h02}, 1, 0, 0);
    chk(u_host.rx[0], 8'h77);
    u_host.run('{8'h21, 8'h00, 8'h30, 8'h00}, 0, 0, 0);
    chk(n_prog, 1);
    wait_idle();
    chk(stream.size(), 1056);
    chk({stream[0], stream[1055]}, 16'hC33C);
    chk(standby, 1'b1);
    u_host.run('{8'h12, 8'h00, 8'h00, 8'h00}, 1, 0, 0);
    chk(u_host.rx[0], 8'hC3);
  endtask
  task automatic t_sec_prog();
    u_host.run('{8'h34, 8'h00, 8'h00, 8'h05, 8'h5C}, 0, 0, 0);
    chk(busy_pin, 1'b0);
    u_host.run('{8'h34, 8'h00, 8'h00, 8'h05, 8'h11}, 0, 0, 0);
    wait_idle();
    u_host.run('{8'h32, 8'h00, 8'h00, 8'h05}, 1, 0, 0);
    chk(u_host.rx[0], 8'h5C);
  endtask
  task automatic t_erase_status();
    u_host.run('{8'h22, 8'hFF, 8'hF8, 8'h00}, 0, 0, 0);
    chk(n_erase, 1);
    chk(page, 13'h1FFF);
    chk(busy_pin, 1'b0);
    wait_idle();
    u_host.run('{8'h30}, 1, 0, 0);
    chk({u_host.rx[0][7], u_host.rx[0][0]}, 2'b10);
    u_host.run('{8'h32, 8'h00, 8'h00, 8'h40}, 1, 0, 0);
    chk(u_host.rx[0], 8'hA5);
    u_host.run('{8'h32, 8'h00, 8'h00, 8'h3F}, 1, 0, 0);
    chk(u_host.rx[0], 8'hFF);
  endtask
  initial begin
    I_SYS_RST = 1'b1;
    I_INTERFACE_SELECT = 1'b1;
    I_BINARY_PAGE = 1'b0;
    I_ARRAY_WREADY = 1'b0;
    repeat (2) @(posedge I_CLK);
    @(negedge I_CLK);
    chk({standby, sdo_oe, lane_oe, busy_pin, prog}, 5'b10010);
    @(posedge I_CLK);
    I_SYS_RST <= 1'b0;
    repeat (8) @(posedge I_CLK);
    t_serial();
    t_partial();
    t_byte();
    t_program();
    t_erase_status();
    t_sec_prog();
    stop_test();
  end
endmodule

// file: link_host.sv
// Host-side link model: framed serial or byte transfers
`timescale 1ns/10ps
module link_host (
  // Link pins toward the device
  output logic o_lclk,
  output logic o_sel_n,
  output logic o_sdi,
  output logic [7:0] o_lane,
  // Read-back levels
  input wire logic i_sdo,
  input wire logic [7:0] i_lane
);
  logic [7:0] rx[$];
  initial begin
    o_lclk = 1'b0;
    o_sel_n = 1'b1;
    o_sdi = 1'b0;
    o_lane = 8'h00;
  end
  task automatic unit(input logic [7:0] tx, input bit bm, output logic [7:0] rb);
    for (int i = bm ? 0 : 7; i >= 0; i--) begin
      o_lclk = 1'b0;
      // serial in idle in byte mode
      o_sdi = bm ? 1'b0 : tx[i];
      o_lane = tx;
      #200 o_lclk = 1'b1;
      #190 rb[i] = i_sdo;
      if (bm) rb = i_lane;
      #10;
    end
  endtask
  task automatic run(input logic [7:0] tx[$], input int nrd, input bit bm, input bit m3);
    logic [7:0] b;
    rx.delete();
    o_lclk = m3;
    #400 o_sel_n = 1'b0;
    #400;
    foreach (tx[k]) unit(tx[k], bm, b);
    repeat (nrd) begin
      unit(8'h00, bm, b);
      rx.push_back(b);
    end
    o_lclk = m3;
    #400 o_sel_n = 1'b1;
    // Released lines flip so stale values cannot pass
    o_sdi = ~o_sdi;
    o_lane = ~o_lane;
    #800;
  endtask
  task automatic noise();
    repeat (16) begin
      #200 o_lclk = ~o_lclk;
      o_sdi = o_lclk;
      o_lane = {8{o_lclk}};
    end
  endtask
endmodule

// file: pin_sync.sv
// Three-stage pin synchroniser; a change counts once stages two and three agree
`timescale 1ns/10ps
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Pins and filtered levels
  input wire logic [W-1:0] i_pin,
  output logic [W-1:0] o_level
);

  logic [W-1:0] stage1;
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
    end else begin
      stage1 <= i_pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Per bit: take the new level only when the last two stages agree
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_level <= RST_VAL;
    end else begin
      o_level <= (stage2 & stage3) | (o_level & (stage2 ^ stage3));
    end
  end

endmodule

// file: skid_buf2.sv
// Two-entry valid/ready buffer
`timescale 1ns/10ps
module skid_buf2 #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst,
  // Filling side
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [W-1:0] i_data,
  // Draining side
  output logic o_valid,
  input wire logic i_ready,
  output logic [W-1:0] o_data
);

  logic [W-1:0] slot [2];
  logic [1:0] count;
  logic rd_idx;
  logic wr_idx;
  logic push;
  logic pop;

  assign o_ready = (count != 2'h2);
  assign o_valid = (count != 2'h0);
  assign push = i_valid && o_ready;
  assign pop = o_valid && i_ready;

  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      count <= 2'h0;
      rd_idx <= 1'b0;
      wr_idx <= 1'b0;
    end else begin
      count <= count + {1'b0, push} - {1'b0, pop};
      if (push) begin
        wr_idx <= ~wr_idx;
      end
      if (pop) begin
        rd_idx <= ~rd_idx;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) begin
      slot[wr_idx] <= i_data;
    end
  end

  assign o_data = slot[rd_idx];

endmodule
